// ---- hdl/bioad_pkg.sv ----
// Purpose: Constants for the bridge I/O window address decoder
// Assumes: Config space is reached one dword at a time with byte enables
// Notes:   Offsets are config-space byte offsets as printed
package bioad_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 32;
  localparam int CFG_ADDR_W = 8;
  localparam int CFG_DATA_W = 32;
  localparam int CFG_BE_W = 4;

  // ==========================================================
  // Config-space offsets of the window registers
  localparam logic [7:0] IO_BASE_LOW_OFF = 8'h1c;
  localparam logic [7:0] IO_LIMIT_LOW_OFF = 8'h1d;
  localparam logic [7:0] IO_BASE_HIGH_OFF = 8'h30;
  localparam logic [7:0] IO_LIMIT_HIGH_OFF = 8'h32;

  // ==========================================================
  // Field layout
  localparam int NIB_MSB = 7;
  localparam int NIB_LSB = 4;
  localparam int HIGH_W = 16;
  localparam logic [3:0] CAP_32BIT = 4'h1;
  localparam logic [11:0] BASE_FILL = 12'h000;
  localparam logic [11:0] LIMIT_FILL = 12'hfff;

  // ==========================================================
  // Reset values
  localparam logic [3:0] BASE_NIB_RST = 4'h0;
  localparam logic [3:0] LIMIT_NIB_RST = 4'h0;
  localparam logic [15:0] BASE_HIGH_RST = 16'h0000;
  localparam logic [15:0] LIMIT_HIGH_RST = 16'h0000;
  localparam logic [31:0] LIMIT_RST_ADDR = 32'h00000fff;

  // ==========================================================
  // ISA aliasing: first 64KB, upper 768 bytes of each 1KB block
  localparam logic [15:0] ISA_HIGH_ZERO = 16'h0000;
  localparam int ISA_SEL_MSB = 9;
  localparam int ISA_SEL_LSB = 8;
  localparam logic [1:0] ISA_LOW_QUARTER = 2'h0;

endpackage

// ---- hdl/bioad_decoder.sv ----
// Purpose: I/O window decode for a two-port bridge, both directions
// Assumes: Requests and enables come from logic on the same clock
// Notes:   Decisions appear one clock after a request, address unchanged
`timescale 1ns/10ps

// What this block does
// - Inside window goes down, outside goes up
// - Forwarded addresses pass through untranslated
// - No downstream I/O without I/O enable
// - No upstream traffic without master enable
// - Master enable also allows upstream memory
// - Base above limit disables the window
// - Window 4KB granular, up to 4GB
// - Base low byte: bits 15:12, nibble 1h
// - Base high word supplies bits 31:16
// - Base resets to zero on either reset
// - Limit low byte: bits 15:12, fill FFFh
// - Limit high word supplies bits 31:16
// - Limit resets to top of bottom 4KB
// - ISA only affects window below 64KB
// - ISA: only low 256 bytes go down
// - ISA: upper 768 bytes go up
// - Otherwise upstream only outside window
// - Above 64KB plain base/limit decode
module bioad_decoder
(
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  input  wire logic                            priBusRst_n,
  input  wire logic                            ioEnable,
  input  wire logic                            masterEnable,
  input  wire logic                            isaEnable,
  input  wire logic                            cfgWrEn,
  input  wire logic                            cfgRdEn,
  input  wire logic [bioad_pkg::CFG_ADDR_W-1:0] cfgAddr,
  input  wire logic [bioad_pkg::CFG_BE_W-1:0]   cfgByteEn,
  input  wire logic [bioad_pkg::CFG_DATA_W-1:0] cfgWrData,
  output logic      [bioad_pkg::CFG_DATA_W-1:0] cfgRdData_r,
  output logic                                  cfgRdValid_r,
  input  wire logic                            priReqValid,
  input  wire logic [bioad_pkg::ADDR_W-1:0]     priReqAddr,
  input  wire logic                            priReqIsIo,
  output logic                                  priFwd_r,
  output logic      [bioad_pkg::ADDR_W-1:0]     priFwdAddr_r,
  input  wire logic                            secReqValid,
  input  wire logic [bioad_pkg::ADDR_W-1:0]     secReqAddr,
  input  wire logic                            secReqIsIo,
  input  wire logic                            secReqIsMem,
  input  wire logic                            secMemHit,
  output logic                                  secFwd_r,
  output logic      [bioad_pkg::ADDR_W-1:0]     secFwdAddr_r,
  output logic                                  secFwdIsIo_r
);
  import bioad_pkg::*;

  // ==========================================================
  // Helper functions

  // Inclusive compare against the assembled window
  function automatic logic inWindow(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    inWindow = (a >= lo) && (a <= hi);
  endfunction

  // ISA alias zone: below 64KB, upper 768 bytes of a 1KB block
  function automatic logic isaAlias(input logic [ADDR_W-1:0] a);
    isaAlias = (a[ADDR_W-1:HIGH_W] == ISA_HIGH_ZERO) &&
      (a[ISA_SEL_MSB:ISA_SEL_LSB] != ISA_LOW_QUARTER);
  endfunction

  // ==========================================================
  // Primary bus reset synchroniser

  logic priRstSync1_r;
  logic priRstSync2_r;

  // Two flops before the window registers see the pin
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      priRstSync1_r <= 1'b0;
      priRstSync2_r <= 1'b0;
    end
    else
    begin
      priRstSync1_r <= priBusRst_n;
      priRstSync2_r <= priRstSync1_r;
    end
  end

  // ==========================================================
  // Config decode

  logic [3:0]        baseNib_r;
  logic [3:0]        limitNib_r;
  logic [HIGH_W-1:0] baseHigh_r;
  logic [HIGH_W-1:0] limitHigh_r;
  logic [3:0]        baseNib_nxt;
  logic [3:0]        limitNib_nxt;
  logic [HIGH_W-1:0] baseHigh_nxt;
  logic [HIGH_W-1:0] limitHigh_nxt;
  logic              hitLowDw;
  logic              hitHighDw;

  // Dword select; the byte lane is the low two offset bits
  assign hitLowDw  = (cfgAddr[7:2] == IO_BASE_LOW_OFF[7:2]);
  assign hitHighDw = (cfgAddr[7:2] == IO_BASE_HIGH_OFF[7:2]);

  // Next values with byte-enable merge
  assign baseNib_nxt = (cfgWrEn && hitLowDw &&
    cfgByteEn[IO_BASE_LOW_OFF[1:0]]) ?
    cfgWrData[8*IO_BASE_LOW_OFF[1:0]+NIB_LSB +: 4] : baseNib_r;
  assign limitNib_nxt = (cfgWrEn && hitLowDw &&
    cfgByteEn[IO_LIMIT_LOW_OFF[1:0]]) ?
    cfgWrData[8*IO_LIMIT_LOW_OFF[1:0]+NIB_LSB +: 4] : limitNib_r;
  assign baseHigh_nxt[7:0] = (cfgWrEn && hitHighDw &&
    cfgByteEn[IO_BASE_HIGH_OFF[1:0]]) ?
    cfgWrData[8*IO_BASE_HIGH_OFF[1:0] +: 8] : baseHigh_r[7:0];
  assign baseHigh_nxt[15:8] = (cfgWrEn && hitHighDw &&
    cfgByteEn[IO_BASE_HIGH_OFF[1:0]+1]) ?
    cfgWrData[8*IO_BASE_HIGH_OFF[1:0]+8 +: 8] : baseHigh_r[15:8];
  assign limitHigh_nxt[7:0] = (cfgWrEn && hitHighDw &&
    cfgByteEn[IO_LIMIT_HIGH_OFF[1:0]]) ?
    cfgWrData[8*IO_LIMIT_HIGH_OFF[1:0] +: 8] : limitHigh_r[7:0];
  assign limitHigh_nxt[15:8] = (cfgWrEn && hitHighDw &&
    cfgByteEn[IO_LIMIT_HIGH_OFF[1:0]+1]) ?
    cfgWrData[8*IO_LIMIT_HIGH_OFF[1:0]+8 +: 8] : limitHigh_r[15:8];

  // Window registers, cleared by chip or primary bus reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      baseNib_r   <= BASE_NIB_RST;
      limitNib_r  <= LIMIT_NIB_RST;
      baseHigh_r  <= BASE_HIGH_RST;
      limitHigh_r <= LIMIT_HIGH_RST;
    end
    else if (!priRstSync2_r)
    begin
      baseNib_r   <= BASE_NIB_RST;
      limitNib_r  <= LIMIT_NIB_RST;
      baseHigh_r  <= BASE_HIGH_RST;
      limitHigh_r <= LIMIT_HIGH_RST;
    end
    else
    begin
      baseNib_r   <= baseNib_nxt;
      limitNib_r  <= limitNib_nxt;
      baseHigh_r  <= baseHigh_nxt;
      limitHigh_r <= limitHigh_nxt;
    end
  end

  // ==========================================================
  // Readback

  logic [CFG_DATA_W-1:0] rdLowDw;
  logic [CFG_DATA_W-1:0] rdHighDw;
  logic [CFG_DATA_W-1:0] cfgRdData_nxt;

  // Low nibbles always read 1h; other lanes read zero
  assign rdLowDw  = {16'h0000, limitNib_r, CAP_32BIT,
                     baseNib_r, CAP_32BIT};
  assign rdHighDw = {limitHigh_r, baseHigh_r};
  assign cfgRdData_nxt = hitLowDw  ? rdLowDw  :
                         hitHighDw ? rdHighDw : '0;

  // Read data held until the next read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfgRdData_r  <= '0;
      cfgRdValid_r <= 1'b0;
    end
    else
    begin
      cfgRdValid_r <= cfgRdEn;
      if (cfgRdEn)
        cfgRdData_r <= cfgRdData_nxt;
    end
  end

  // ==========================================================
  // Window assembly and decisions

  logic [ADDR_W-1:0] baseAddr;
  logic [ADDR_W-1:0] limitAddr;
  logic              priIsaBlock;
  logic              secIsaPass;
  logic              priDown;
  logic              secUpIo;
  logic              secUpMem;

  // 4KB-aligned bounds from the register fields
  assign baseAddr  = {baseHigh_r, baseNib_r, BASE_FILL};
  assign limitAddr = {limitHigh_r, limitNib_r, LIMIT_FILL};

  // ISA alias only matters inside the window
  assign priIsaBlock = isaEnable && isaAlias(priReqAddr);
  assign secIsaPass  = isaEnable && isaAlias(secReqAddr);

  // Downstream: enabled I/O inside window, not ISA-blocked
  assign priDown = priReqValid && priReqIsIo && ioEnable &&
    inWindow(priReqAddr, baseAddr, limitAddr) &&
    !priIsaBlock;

  // Upstream I/O: outside window, or ISA alias region
  assign secUpIo = secReqValid && secReqIsIo && masterEnable &&
    (!inWindow(secReqAddr, baseAddr, limitAddr) ||
     secIsaPass);

  // Upstream memory: master enable and not claimed downstream
  assign secUpMem = secReqValid && secReqIsMem && masterEnable &&
    !secMemHit;

  // Registered decisions, address forwarded unchanged
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      priFwd_r     <= 1'b0;
      priFwdAddr_r <= '0;
      secFwd_r     <= 1'b0;
      secFwdAddr_r <= '0;
      secFwdIsIo_r <= 1'b0;
    end
    else
    begin
      priFwd_r     <= priDown;
      secFwd_r     <= secUpIo || secUpMem;
      secFwdIsIo_r <= secUpIo;
      if (priReqValid)
        priFwdAddr_r <= priReqAddr;
      if (secReqValid)
        secFwdAddr_r <= secReqAddr;
    end
  end

  // ==========================================================
  // Assertions

  AST_DOWN_FWD: assert property (@(posedge clk) disable iff (!arst_n)
    priDown |=> priFwd_r && (priFwdAddr_r == $past(priReqAddr)))
    else $error("in-window primary I/O not forwarded");

  AST_UP_ADDR: assert property (@(posedge clk) disable iff (!arst_n)
    secReqValid ##1 secFwd_r |-> secFwdAddr_r == $past(secReqAddr))
    else $error("upstream address altered");

  AST_NO_IO_EN: assert property (@(posedge clk) disable iff (!arst_n)
    !ioEnable |=> !priFwd_r)
    else $error("downstream forward without I/O enable");

  AST_NO_MASTER: assert property (@(posedge clk) disable iff (!arst_n)
    !masterEnable |=> !secFwd_r)
    else $error("upstream forward without master enable");

  AST_MEM_UP: assert property (@(posedge clk) disable iff (!arst_n)
    (secReqValid && secReqIsMem && masterEnable && !secMemHit)
    |=> secFwd_r && !secFwdIsIo_r)
    else $error("upstream memory not forwarded");

  AST_WIN_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    (baseAddr > limitAddr) && secReqValid && secReqIsIo && masterEnable
    |=> secFwd_r && secFwdIsIo_r && !priFwd_r)
    else $error("disabled window still decodes");

  AST_BOUNDS: assert property (@(posedge clk) disable iff (!arst_n)
    (baseAddr[11:0] == BASE_FILL) && (limitAddr[11:0] == LIMIT_FILL))
    else $error("window not 4KB aligned");

  AST_CAP_NIB: assert property (@(posedge clk) disable iff (!arst_n)
    cfgRdEn && hitLowDw |=> (cfgRdData_r[3:0] == CAP_32BIT) &&
    (cfgRdData_r[11:8] == CAP_32BIT) &&
    (cfgRdData_r[7:4] == $past(baseNib_r)))
    else $error("low dword readback wrong");

  AST_RST_WIN: assert property (@(posedge clk) disable iff (!arst_n)
    !priRstSync2_r |=> (baseAddr == '0) && (limitAddr == LIMIT_RST_ADDR))
    else $error("window not reset by primary bus reset");

  AST_ISA_DOWN: assert property (@(posedge clk) disable iff (!arst_n)
    (priReqValid && isaEnable && isaAlias(priReqAddr)) |=> !priFwd_r)
    else $error("ISA alias forwarded downstream");

  AST_ISA_UP: assert property (@(posedge clk) disable iff (!arst_n)
    (secReqValid && secReqIsIo && isaEnable && masterEnable &&
     isaAlias(secReqAddr)) |=> secFwd_r && secFwdIsIo_r)
    else $error("ISA alias not forwarded upstream");

  AST_IN_WIN_UP: assert property (@(posedge clk) disable iff (!arst_n)
    (secReqValid && secReqIsIo && !secReqIsMem && !secIsaPass &&
     inWindow(secReqAddr, baseAddr, limitAddr)) |=> !secFwd_r)
    else $error("in-window secondary I/O forwarded upstream");

endmodule

// ---- tb/bioad_initiator_model.sv ----
// Purpose: Initiators on the primary and secondary buses of the decoder
// Assumes: Called from the bench at a falling clock edge
// Notes:   Released address lines show the inverse of the last address
`timescale 1ns/10ps

module bioad_initiator_model
(
  input  wire logic                         clk,
  output logic                              priReqValid,
  output logic [bioad_pkg::ADDR_W-1:0]      priReqAddr,
  output logic                              priReqIsIo,
  output logic                              secReqValid,
  output logic [bioad_pkg::ADDR_W-1:0]      secReqAddr,
  output logic                              secReqIsIo,
  output logic                              secReqIsMem,
  output logic                              secMemHit,
  input  wire logic                         priFwd_r,
  input  wire logic [bioad_pkg::ADDR_W-1:0] priFwdAddr_r,
  input  wire logic                         secFwd_r,
  input  wire logic [bioad_pkg::ADDR_W-1:0] secFwdAddr_r,
  input  wire logic                         secFwdIsIo_r
);
  import bioad_pkg::*;

  // ==========================================================
  // Idle buses at time zero
  initial
  begin
    {priReqValid, priReqIsIo, secReqValid} = 3'h0;
    {secReqIsIo, secReqIsMem, secMemHit} = 3'h0;
    priReqAddr = 32'h0;
    secReqAddr = 32'h0;
  end

  // One primary I/O request, result taken one cycle later
  task automatic priIssue(input logic [31:0] a, output logic f,
                          output logic [31:0] fa);
    priReqValid = 1'b1;
    priReqAddr = a;
    priReqIsIo = 1'b1;
    @(negedge clk);
    f = priFwd_r;
    fa = priFwdAddr_r;
    priReqValid = 1'b0;
    priReqAddr = ~a;  // No stale address after release
    @(negedge clk);
  endtask

  // One secondary request, I/O or memory
  task automatic secIssue(input logic [31:0] a, input logic io, mem, hit,
                          output logic f, fio, output logic [31:0] fa);
    secReqValid = 1'b1;
    secReqAddr = a;
    secReqIsIo = io;
    secReqIsMem = mem;
    secMemHit = hit;
    @(negedge clk);
    f = secFwd_r;
    fio = secFwdIsIo_r;
    fa = secFwdAddr_r;
    secReqValid = 1'b0;
    secReqAddr = ~a;  // No stale address after release
    @(negedge clk);
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the bridge I/O window decoder
// Assumes: Inputs change at the falling clock edge
// Notes:   Expected values follow the window and ISA decode rules
`timescale 1ns/10ps

module tb_top;
  import bioad_pkg::*;

  // ==========================================================
  // Signals
  logic        clk, arst_n, priBusRst_n, ioEnable, masterEnable, isaEnable;
  logic        cfgWrEn, cfgRdEn, cfgRdValid_r;
  logic [7:0]  cfgAddr;
  logic [3:0]  cfgByteEn;
  logic [31:0] cfgWrData, cfgRdData_r, priReqAddr, priFwdAddr_r;
  logic [31:0] secReqAddr, secFwdAddr_r;
  logic        priReqValid, priReqIsIo, priFwd_r, secReqValid, secReqIsIo;
  logic        secReqIsMem, secMemHit, secFwd_r, secFwdIsIo_r;
  int          mismatches, checks;

  bioad_decoder dut_u (.clk(clk), .arst_n(arst_n), .priBusRst_n(priBusRst_n),
    .ioEnable(ioEnable), .masterEnable(masterEnable), .isaEnable(isaEnable),
    .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData_r(cfgRdData_r),
    .cfgRdValid_r(cfgRdValid_r), .priReqValid(priReqValid),
    .priReqAddr(priReqAddr), .priReqIsIo(priReqIsIo), .priFwd_r(priFwd_r),
    .priFwdAddr_r(priFwdAddr_r), .secReqValid(secReqValid),
    .secReqAddr(secReqAddr), .secReqIsIo(secReqIsIo),
    .secReqIsMem(secReqIsMem), .secMemHit(secMemHit), .secFwd_r(secFwd_r),
    .secFwdAddr_r(secFwdAddr_r), .secFwdIsIo_r(secFwdIsIo_r));

  bioad_initiator_model model_u (.clk(clk), .priReqValid(priReqValid),
    .priReqAddr(priReqAddr), .priReqIsIo(priReqIsIo),
    .secReqValid(secReqValid), .secReqAddr(secReqAddr),
    .secReqIsIo(secReqIsIo), .secReqIsMem(secReqIsMem),
    .secMemHit(secMemHit), .priFwd_r(priFwd_r), .priFwdAddr_r(priFwdAddr_r),
    .secFwd_r(secFwd_r), .secFwdAddr_r(secFwdAddr_r),
    .secFwdIsIo_r(secFwdIsIo_r));

  // ==========================================================
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  // ==========================================================
  // Compare, verdict and access tasks
  task automatic cmp(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cfgWr(input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d);
    {cfgWrEn, cfgAddr, cfgByteEn, cfgWrData} = {1'b1, a, be, d};
    @(negedge clk);
    cfgWrEn = 1'b0;
    @(negedge clk);
  endtask

  task automatic cfgRd(input logic [7:0] a, input logic [31:0] exp);
    cfgRdEn = 1'b1;
    cfgAddr = a;
    @(negedge clk);
    cmp("cfgRdValid_r", 32'h1, {31'h0, cfgRdValid_r});
    cmp("cfgRdData_r", exp, cfgRdData_r);
    cfgRdEn = 1'b0;
    @(negedge clk);
  endtask

  task automatic pri(input logic [31:0] a, input logic expF);
    logic        f;
    logic [31:0] fa;
    model_u.priIssue(a, f, fa);
    cmp("priFwd_r", {31'h0, expF}, {31'h0, f});
    if (expF)
      cmp("priFwdAddr_r", a, fa);
  endtask

  task automatic sec(input logic [31:0] a, input logic io, mem, hit, expF);
    logic        f, fio;
    logic [31:0] fa;
    model_u.secIssue(a, io, mem, hit, f, fio, fa);
    cmp("secFwd_r", {31'h0, expF}, {31'h0, f});
    if (expF)
    begin
      cmp("secFwdAddr_r", a, fa);
      cmp("secFwdIsIo_r", {31'h0, io}, {31'h0, fio});
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    // Primary bus reset pin idle high; only chip reset held low
    {arst_n, priBusRst_n, ioEnable, masterEnable, isaEnable} = 5'h08;
    {cfgWrEn, cfgRdEn, cfgAddr, cfgByteEn, cfgWrData} = 46'h0;
    mismatches = 0;
    checks = 0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    cfgRd(8'h1c, 32'h00000101);
    cfgRd(8'h30, 32'h00000000);
    cfgRd(8'h20, 32'h00000000);
    {ioEnable, masterEnable} = 2'h3;
    pri(32'h00000ffc, 1'b1);
    pri(32'h00001000, 1'b0);
    ioEnable = 1'b0;
    pri(32'h00000010, 1'b0);
    ioEnable = 1'b1;
    // Window 0x12000..0x13fff, low nibbles not writable
    cfgWr(8'h30, 4'hf, 32'h00010001);
    cfgWr(8'h1c, 4'hf, 32'hffff3020);
    cfgRd(8'h1c, 32'h00003121);
    cfgRd(8'h30, 32'h00010001);
    isaEnable = 1'b1;
    pri(32'h00011fff, 1'b0);
    pri(32'h00012000, 1'b1);
    pri(32'h00012100, 1'b1);
    pri(32'h00013fff, 1'b1);
    pri(32'h00014000, 1'b0);
    sec(32'h00013100, 1'b1, 1'b0, 1'b0, 1'b0);
    sec(32'h00014000, 1'b1, 1'b0, 1'b0, 1'b1);
    // Lanes 0-1 only: base high cleared, window 0x2000..0x13fff
    cfgWr(8'h30, 4'h3, 32'hffff0000);
    cfgRd(8'h30, 32'h00010000);
    pri(32'h00002100, 1'b0);
    pri(32'h00002400, 1'b1);
    pri(32'h000024ff, 1'b1);
    pri(32'h00002500, 1'b0);
    sec(32'h00002100, 1'b1, 1'b0, 1'b0, 1'b1);
    sec(32'h00002400, 1'b1, 1'b0, 1'b0, 1'b0);
    isaEnable = 1'b0;
    pri(32'h00002100, 1'b1);
    sec(32'h00002100, 1'b1, 1'b0, 1'b0, 1'b0);
    // Base 0x5000 above limit 0x3fff turns the window off
    cfgWr(8'h30, 4'hc, 32'h00000000);
    cfgWr(8'h1c, 4'h1, 32'h00000050);
    pri(32'h00005000, 1'b0);
    pri(32'h00003000, 1'b0);
    sec(32'h00003000, 1'b1, 1'b0, 1'b0, 1'b1);
    masterEnable = 1'b0;
    sec(32'h00009000, 1'b1, 1'b0, 1'b0, 1'b0);
    sec(32'h00009000, 1'b0, 1'b1, 1'b0, 1'b0);
    masterEnable = 1'b1;
    sec(32'h00009000, 1'b0, 1'b1, 1'b0, 1'b1);
    sec(32'h00009000, 1'b0, 1'b1, 1'b1, 1'b0);
    // Primary bus reset restores the default window
    priBusRst_n = 1'b0;
    repeat (4) @(negedge clk);
    priBusRst_n = 1'b1;
    repeat (3) @(negedge clk);
    cfgRd(8'h1c, 32'h00000101);
    cfgRd(8'h30, 32'h00000000);
    pri(32'h00000ffc, 1'b1);
    wrap_up();
  end
endmodule
